// ---- src/mac_consts.vh ----
// Register offsets, field positions, reset values and timing counts for the math accelerator
`ifndef MAC_CONSTS_VH
`define MAC_CONSTS_VH

// Register indices; the AXI4-Lite byte address is four times the index
`define MAC_OFF_SHIFT_NORM_CTRL 8'hd1
`define MAC_OFF_STATUS_CTRL     8'hd2
`define MAC_OFF_OPERAND_A       8'hd3
`define MAC_OFF_OPERAND_B       8'hd4
`define MAC_OFF_ACCUM           8'hd5
`define MAC_ADDR_W              8

// Shift / normalize control fields
`define MAC_SNC_LSHIFT          7
`define MAC_SNC_NORM            6
`define MAC_SNC_CNT_HI          4
`define MAC_SNC_CNT_LO          0

// Status / control fields
`define MAC_STC_ACTIVE          7
`define MAC_STC_OVF             6
`define MAC_STC_CLR_ACC         4

`define MAC_SNC_RESET           8'h00

// Machine cycle is 4 core clocks
`define MAC_CLK_PER_MC          4
`define MAC_DIV_MC              9
`define MAC_MUL_MC              6
`define MAC_SHF_MC              9

// AXI responses
`define MAC_RESP_OKAY           2'b00
`define MAC_RESP_SLVERR         2'b10

`endif

// ---- src/mac_alu.v ----
// Combinational arithmetic unit: divide, multiply, shift and normalize
`timescale 1ns/1ps
`default_nettype none
`include "mac_consts.vh"

module mac_alu (
	// Operands
	input  wire [31:0] op_a_i,
	input  wire [15:0] op_b_i,
	input  wire [7:0]  snc_i,
	// Results
	output reg  [31:0] quot_o,
	output reg  [15:0] rem_o,
	output reg  [31:0] prod_o,
	output reg  [31:0] shift_o,
	output reg  [31:0] norm_o,
	output reg  [4:0]  exp_o
);

	integer i;
	reg [4:0]  cnt;
	reg [31:0] rem_w;

	always @* begin
		cnt   = snc_i[`MAC_SNC_CNT_HI:`MAC_SNC_CNT_LO];
		rem_w = 32'h00000000;
		// Divide by zero returns all ones, remainder keeps dividend low half
		if (op_b_i == 16'h0000) begin
			quot_o = 32'hffffffff;
			rem_o  = op_a_i[15:0];
		end else begin
			quot_o = op_a_i / {16'h0000, op_b_i};
			rem_w  = op_a_i % {16'h0000, op_b_i};
			rem_o  = rem_w[15:0];
		end
		prod_o = {16'h0000, op_a_i[15:0]} * {16'h0000, op_b_i};
		if (snc_i[`MAC_SNC_LSHIFT])
			shift_o = op_a_i << cnt;
		else
			shift_o = op_a_i >> cnt;
		norm_o = op_a_i;
		exp_o  = 5'h00;
		for (i = 0; i < 31; i = i + 1) begin
			if (!norm_o[31] && norm_o != 32'h00000000) begin
				norm_o = norm_o << 1;
				exp_o  = exp_o + 5'h01;
			end
		end
	end

endmodule // mac_alu
`default_nettype wire

// ---- src/mac_top.v ----
// Math accelerator with 40-bit accumulator behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_consts.vh"

module mac_top #(
	parameter CLK_HZ = 20000000
) (
	// Clock and reset
	input  wire        core_clk_i,
	input  wire        resetn_i,
	// AXI4-Lite write address
	input  wire [31:0] s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	// AXI4-Lite read address
	input  wire [31:0] s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// Status
	output reg         busy_o
);

	// Counts reach 36, so the counter needs six bits
	localparam integer DIV_CLK_I = `MAC_DIV_MC * `MAC_CLK_PER_MC;
	localparam integer MUL_CLK_I = `MAC_MUL_MC * `MAC_CLK_PER_MC;
	localparam integer SHF_CLK_I = `MAC_SHF_MC * `MAC_CLK_PER_MC;
	localparam [5:0]   DIV_CLK   = DIV_CLK_I[5:0];
	localparam [5:0]   MUL_CLK   = MUL_CLK_I[5:0];
	localparam [5:0]   SHF_CLK   = SHF_CLK_I[5:0];

	// Sequencer states
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_A1   = 4'h1;
	localparam [3:0] ST_A2   = 4'h2;
	localparam [3:0] ST_A3   = 4'h3;
	localparam [3:0] ST_A4   = 4'h4;
	localparam [3:0] ST_DB1  = 4'h5;
	localparam [3:0] ST_MB1  = 4'h6;
	localparam [3:0] ST_MB2  = 4'h7;
	localparam [3:0] ST_MA1  = 4'h8;
	localparam [3:0] ST_RUN  = 4'h9;
	localparam [3:0] ST_BAD  = 4'ha;

	// Operation kinds
	localparam [2:0] OP_NONE = 3'h0;
	localparam [2:0] OP_DIV  = 3'h1;
	localparam [2:0] OP_MUL  = 3'h2;
	localparam [2:0] OP_SHF  = 3'h3;
	localparam [2:0] OP_NRM  = 3'h4;

	function [7:0] byte_of;
		input [39:0] v;
		input [2:0]  idx;
		begin
			byte_of = v[idx*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Storage

	reg  [3:0]  state;
	reg  [2:0]  op;
	reg  [5:0]  run_cnt;
	reg  [31:0] reg_a;
	reg  [15:0] reg_b;
	reg  [7:0]  snc;
	reg  [39:0] acc;
	reg         ovf;
	reg  [1:0]  a_idx;
	reg         b_idx;
	reg  [2:0]  c_idx;
	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	wire [31:0] quot;
	wire [15:0] rem;
	wire [31:0] prod;
	wire [31:0] shf;
	wire [31:0] nrm;
	wire [4:0]  nexp;

	mac_alu u_alu (
		.op_a_i  (reg_a),
		.op_b_i  (reg_b),
		.snc_i   (snc),
		.quot_o  (quot),
		.rem_o   (rem),
		.prod_o  (prod),
		.shift_o (shf),
		.norm_o  (nrm),
		.exp_o   (nexp)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake

	wire       wr_go = (aw_held || (s_axi_awvalid_i && s_axi_awready_o)) &&
	                   (w_held || (s_axi_wvalid_i && s_axi_wready_o)) && !s_axi_bvalid_o;
	// Word addressed: index sits in bits 9:2, misaligned addresses miss
	wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_i[9:2];
	wire [31:0] wr_dat = w_held ? w_data : s_axi_wdata_i;
	wire       wr_lane = w_held ? w_strb[0] : s_axi_wstrb_i[0];
	wire       aw_hit  = (s_axi_awaddr_i[31:10] == 22'h000000) && (s_axi_awaddr_i[1:0] == 2'b00);
	reg        aw_ok;
	// Address taken this edge has no registered hit yet
	wire       wr_ok   = aw_held ? aw_ok : aw_hit;
	wire [7:0] wbyte = wr_dat[7:0];
	wire       rd_go = s_axi_arvalid_i && s_axi_arready_o;
	wire [7:0] rd_addr = s_axi_araddr_i[9:2];
	wire       rd_hi_ok = (s_axi_araddr_i[31:10] == 22'h000000) && (s_axi_araddr_i[1:0] == 2'b00);
	wire       busy = (state == ST_RUN);

	// Port accesses that count as sequencing events; other offsets pass through
	wire wr_en = wr_go && wr_lane && wr_ok;
	wire wa = wr_en && wr_addr == `MAC_OFF_OPERAND_A;
	wire wb = wr_en && wr_addr == `MAC_OFF_OPERAND_B;
	wire wc = wr_en && wr_addr == `MAC_OFF_ACCUM;
	wire wn = wr_en && wr_addr == `MAC_OFF_SHIFT_NORM_CTRL;
	wire ws = wr_en && wr_addr == `MAC_OFF_STATUS_CTRL;
	wire ra = rd_go && rd_hi_ok && rd_addr == `MAC_OFF_OPERAND_A;
	wire rb = rd_go && rd_hi_ok && rd_addr == `MAC_OFF_OPERAND_B;
	wire rc = rd_go && rd_hi_ok && rd_addr == `MAC_OFF_ACCUM;

	// Software clearing the busy bit restarts the sequencer
	wire restart = ws && !wbyte[`MAC_STC_ACTIVE];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer and datapath

	reg [39:0] sum;
	always @* begin
		sum = acc;
		if (op == OP_DIV)
			sum = acc + {8'h00, quot};
		else if (op == OP_MUL)
			sum = acc + {8'h00, prod};
	end

	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state   <= ST_IDLE;
			op      <= OP_NONE;
			run_cnt <= 6'h00;
			reg_a   <= 32'h00000000;
			reg_b   <= 16'h0000;
			snc     <= `MAC_SNC_RESET;
			acc     <= 40'h0000000000;
			ovf     <= 1'b0;
			a_idx   <= 2'h0;
			b_idx   <= 1'b0;
			c_idx   <= 3'h0;
			busy_o  <= 1'b0;
		end else begin
			if (restart) begin
				state <= ST_IDLE;
				op    <= OP_NONE;
				a_idx <= 2'h0;
				b_idx <= 1'b0;
				busy_o <= 1'b0;
				if (wbyte[`MAC_STC_CLR_ACC])
					acc <= 40'h0000000000;
			end else begin
				case (state)
				ST_IDLE: begin
					if (wa) begin
						reg_a <= {24'h000000, wbyte};
						state <= ST_A1;
					end else if (wb) begin
						reg_b <= {8'h00, wbyte};
						state <= ST_MB1;
					end else if (wn) begin
						state <= ST_BAD;
					end
				end
				ST_A1: begin
					if (wa) begin
						reg_a[15:8] <= wbyte;
						state <= ST_A2;
					end else if (wb || wn) begin
						state <= ST_BAD;
					end
				end
				ST_A2: begin
					if (wa) begin
						reg_a[23:16] <= wbyte;
						state <= ST_A3;
					end else if (wb) begin
						// 16-bit numerator: A holds only two bytes
						reg_b <= {8'h00, wbyte};
						state <= ST_DB1;
					end else if (wn) begin
						state <= ST_BAD;
					end
				end
				ST_A3: begin
					if (wa) begin
						reg_a[31:24] <= wbyte;
						state <= ST_A4;
					end else if (wb || wn) begin
						state <= ST_BAD;
					end
				end
				ST_A4: begin
					if (wb) begin
						reg_b <= {8'h00, wbyte};
						state <= ST_DB1;
					end else if (wn) begin
						snc     <= wbyte;
						op      <= wbyte[`MAC_SNC_NORM] ? OP_NRM : OP_SHF;
						run_cnt <= SHF_CLK;
						busy_o  <= 1'b1;
						state   <= ST_RUN;
					end else if (wa) begin
						state <= ST_BAD;
					end
				end
				ST_DB1: begin
					if (wb) begin
						reg_b[15:8] <= wbyte;
						op      <= OP_DIV;
						run_cnt <= DIV_CLK;
						busy_o  <= 1'b1;
						state   <= ST_RUN;
					end else if (wa || wn) begin
						state <= ST_BAD;
					end
				end
				ST_MB1: begin
					if (wb) begin
						reg_b[15:8] <= wbyte;
						state <= ST_MB2;
					end else if (wa || wn) begin
						state <= ST_BAD;
					end
				end
				ST_MB2: begin
					if (wa) begin
						reg_a <= {24'h000000, wbyte};
						state <= ST_MA1;
					end else if (wb || wn) begin
						state <= ST_BAD;
					end
				end
				ST_MA1: begin
					if (wa) begin
						reg_a[15:8] <= wbyte;
						op      <= OP_MUL;
						run_cnt <= MUL_CLK;
						busy_o  <= 1'b1;
						state   <= ST_RUN;
					end else if (wb || wn) begin
						state <= ST_BAD;
					end
				end
				ST_RUN: begin
					if (wa || wb || wc || ra || rb || rc) begin
						state <= ST_BAD;
					end else if (run_cnt == 6'h01) begin
						// Results land in A/B the same edge busy drops
						busy_o <= 1'b0;
						a_idx  <= 2'h3;
						b_idx  <= 1'b1;
						state  <= ST_IDLE;
						acc    <= sum;
						ovf    <= (op == OP_DIV || op == OP_MUL) && (sum < acc);
						case (op)
						OP_DIV: begin
							reg_a <= quot;
							reg_b <= rem;
						end
						OP_MUL: reg_a <= prod;
						OP_SHF: reg_a <= shf;
						OP_NRM: begin
							reg_a <= nrm;
							snc[`MAC_SNC_CNT_HI:`MAC_SNC_CNT_LO] <= nexp;
						end
						default: reg_a <= reg_a;
						endcase
					end else begin
						run_cnt <= run_cnt - 6'h01;
					end
				end
				ST_BAD: begin
					// Corrupted: stays busy until software clears it
					busy_o <= 1'b1;
				end
				default: state <= ST_IDLE;
				endcase
				// Any data port read or accumulator write while operands are half loaded is out of order
				if (state != ST_IDLE && state != ST_RUN && state != ST_BAD && (ra || rb || rc || wc))
					state <= ST_BAD;
				// Result readback walks bytes MSB first
				if (state != ST_RUN) begin
					if (ra)
						a_idx <= a_idx - 2'h1;
					if (rb)
						b_idx <= ~b_idx;
				end
				if (!busy) begin
					if (wc) begin
						acc[c_idx*8 +: 8] <= wbyte;
						c_idx <= (c_idx == 3'h4) ? 3'h0 : c_idx + 3'h1;
					end else if (rc) begin
						c_idx <= (c_idx == 3'h0) ? 3'h4 : c_idx - 3'h1;
					end
				end
				if (wn && state != ST_A4 && state != ST_RUN)
					snc <= wbyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (rd_addr)
		`MAC_OFF_SHIFT_NORM_CTRL: rd_byte = snc;
		`MAC_OFF_STATUS_CTRL:     rd_byte = {busy_o, ovf, 6'h00};
		`MAC_OFF_OPERAND_A:       rd_byte = byte_of({8'h00, reg_a}, {1'b0, a_idx});
		`MAC_OFF_OPERAND_B:       rd_byte = byte_of({24'h000000, reg_b}, {2'b00, b_idx});
		`MAC_OFF_ACCUM:           rd_byte = byte_of(acc, (c_idx == 3'h0) ? 3'h4 : c_idx - 3'h1);
		default:                  rd_byte = 8'h00;
		endcase
	end

	wire rd_mapped = rd_hi_ok && rd_addr >= `MAC_OFF_SHIFT_NORM_CTRL && rd_addr <= `MAC_OFF_ACCUM;
	wire wr_mapped = wr_addr >= `MAC_OFF_SHIFT_NORM_CTRL && wr_addr <= `MAC_OFF_ACCUM;

	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `MAC_RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rresp_o   <= `MAC_RESP_OKAY;
			s_axi_rdata_o   <= 32'h00000000;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			aw_ok   <= 1'b0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else begin
			s_axi_awready_o <= !aw_held && !s_axi_awready_o && !s_axi_bvalid_o && !wr_go;
			s_axi_wready_o  <= !w_held && !s_axi_wready_o && !s_axi_bvalid_o && !wr_go;
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr <= s_axi_awaddr_i[9:2];
				aw_ok   <= aw_hit;
				aw_held <= !wr_go;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				w_held <= !wr_go;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (wr_ok && wr_mapped) ? `MAC_RESP_OKAY : `MAC_RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
			s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
			if (rd_go) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= {24'h000000, rd_mapped ? rd_byte : 8'h00};
				s_axi_rresp_o  <= rd_mapped ? `MAC_RESP_OKAY : `MAC_RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

endmodule // mac_top
`default_nettype wire

// ---- sim/mac_checker.sv ----
// Bus and busy-flag checks for the math accelerator top
`timescale 1ns/1ps
`default_nettype none
module mac_checker (
	// Clock and reset
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	// Bus handshakes
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Status
	input wire logic        busy_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////
// Saturating count so a long corrupted busy never wraps short
logic [7:0] busy_cnt;
always @(posedge core_clk_i or negedge resetn_i) begin
	if (!resetn_i)
		busy_cnt <= 8'h00;
	else if (!busy_o)
		busy_cnt <= 8'h00;
	else if (busy_cnt != 8'hff)
		busy_cnt <= busy_cnt + 8'h01;
end
sequence rd_take;
	s_axi_arvalid_i && s_axi_arready_o;
endsequence
sequence rd_unmapped;
	rd_take ##0 (s_axi_araddr_i < 32'h344 || s_axi_araddr_i > 32'h354 || s_axi_araddr_i[1:0] != 2'b00);
endsequence
////////////////////////////////////////////////////////////////
a_rd_answer: assert property (rd_take |=> s_axi_rvalid_o)
	else $error("read not answered next cycle");
a_rd_unmapped: assert property (rd_unmapped |=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0)
	else $error("unmapped read not refused");
a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
	else $error("read data dropped before taken");
a_rd_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
	else $error("read upper lanes not zero");
a_wr_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
	else $error("write response dropped");
a_wr_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
	else $error("write taken while response pending");
a_busy_cause: assert property ($rose(busy_o) |-> $past(s_axi_wready_o) || $past(s_axi_arready_o) || $past(s_axi_wready_o, 2) || $past(s_axi_arready_o, 2))
	else $error("busy rose without an access");
a_busy_len: assert property ($fell(busy_o) |-> busy_cnt >= 8'd24)
	else $error("busy cleared too early");
endmodule // mac_checker
`default_nettype wire

// ---- sim/mac_cpu_model.sv ----
// Core-side bus master model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mac_cpu_model (
	// Clock
	input wire logic        core_clk_i,
	// Write channels
	output logic     [31:0] awaddr_o,
	output logic            awvalid_o,
	input wire logic        awready_i,
	output logic     [31:0] wdata_o,
	output logic            wvalid_o,
	input wire logic        wready_i,
	input wire logic [1:0]  bresp_i,
	input wire logic        bvalid_i,
	output logic            bready_o,
	// Read channels
	output logic     [31:0] araddr_o,
	output logic            arvalid_o,
	input wire logic        arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0]  rresp_i,
	input wire logic        rvalid_i,
	output logic            rready_o,
	// Hang flag
	output logic            hung_o
);
initial begin
	{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
	{araddr_o, arvalid_o, rready_o, hung_o} = '0;
end
////////////////////////////////////////////////////////////////
task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
	int n;
	@(posedge core_clk_i);
	awaddr_o <= {22'h0, a, 2'b00};
	wdata_o <= {24'h0, d};
	awvalid_o <= 1'b1;
	wvalid_o <= 1'b1;
	bready_o <= 1'b1;
	for (n = 0; n < 200; n++) begin
		@(posedge core_clk_i);
		if (awready_i) awaddr_o <= ~awaddr_o;
		if (awready_i) awvalid_o <= 1'b0;
		if (wready_i) wdata_o <= ~wdata_o;
		if (wready_i) wvalid_o <= 1'b0;
		if (bvalid_i) break;
	end
	bready_o <= 1'b0;
	r = bresp_i;
	if (n == 200) hung_o <= 1'b1;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
	int n;
	@(posedge core_clk_i);
	araddr_o <= {22'h0, a, 2'b00};
	arvalid_o <= 1'b1;
	rready_o <= 1'b1;
	for (n = 0; n < 200; n++) begin
		@(posedge core_clk_i);
		if (arready_i) araddr_o <= ~araddr_o;
		if (arready_i) arvalid_o <= 1'b0;
		if (rvalid_i) break;
	end
	rready_o <= 1'b0;
	d = rdata_i[7:0];
	r = rresp_i;
	if (n == 200) hung_o <= 1'b1;
endtask
endmodule // mac_cpu_model
`default_nettype wire

// ---- sim/math_accelerator_mac_tb.sv ----
// Self-checking bench for the math accelerator
`timescale 1ns/1ps
`default_nettype none
`include "mac_consts.vh"
module math_accelerator_mac_tb;
logic        core_clk_i = 1'b0;
logic        resetn_i = 1'b0;
logic [31:0] aw_a, w_d, ar_a, r_d;
logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, busy, hung;
logic [1:0]  b_resp, r_resp;
int          num_errors = 0;
int          checks = 0;
localparam logic [7:0] A = `MAC_OFF_OPERAND_A;
localparam logic [7:0] B = `MAC_OFF_OPERAND_B;
localparam logic [7:0] C = `MAC_OFF_ACCUM;
localparam logic [7:0] SN = `MAC_OFF_SHIFT_NORM_CTRL;
localparam logic [7:0] ST = `MAC_OFF_STATUS_CTRL;
always #25 core_clk_i = ~core_clk_i;
mac_top i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
	.s_axi_awready_o(aw_r), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r),
	.s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
	.s_axi_arready_o(ar_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r),
	.busy_o(busy));
mac_cpu_model i_cpu (.core_clk_i(core_clk_i), .awaddr_o(aw_a), .awvalid_o(aw_v), .awready_i(aw_r), .wdata_o(w_d),
	.wvalid_o(w_v), .wready_i(w_r), .bresp_i(b_resp), .bvalid_i(b_v), .bready_o(b_r), .araddr_o(ar_a),
	.arvalid_o(ar_v), .arready_i(ar_r), .rdata_i(r_d), .rresp_i(r_resp), .rvalid_i(r_v), .rready_o(r_r), .hung_o(hung));
////////////////////////////////////////////////////////////////
task automatic tally_and_finish;
	$display("errors=%0d checks=%0d", num_errors, checks);
	if (num_errors == 0 && checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
	checks++;
	if (got !== exp) begin
		num_errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic w(input logic [7:0] a, input logic [7:0] d);
	logic [1:0] r;
	i_cpu.wr(a, d, r);
	cmp(r, 2'b00);
endtask
task automatic wrn(input logic [7:0] a, input int n, input logic [39:0] v);
	logic [39:0] t;
	t = v;
	repeat (n) begin
		w(a, t[7:0]);
		t = t >> 8;
	end
endtask
task automatic rdn(input logic [7:0] a, input int n, output logic [39:0] v);
	logic [7:0] d;
	logic [1:0] r;
	v = '0;
	repeat (n) begin
		i_cpu.rd(a, d, r);
		v = {v[31:0], d};
	end
endtask
// Polls status like software would; also guards accumulator access
task automatic wait_idle;
	logic [7:0] s;
	logic [1:0] r;
	int n;
	for (n = 0; n < 100; n++) begin
		i_cpu.rd(ST, s, r);
		if (!s[7]) break;
	end
	if (n == 100) begin
		num_errors++;
		tally_and_finish();
	end
endtask
////////////////////////////////////////////////////////////////
task automatic t_div32;
	logic [39:0] v;
	logic [7:0] s;
	logic [1:0] r;
	w(A, 8'h78);
	i_cpu.rd(SN, s, r);
	cmp(r, 2'b00);
	i_cpu.rd(8'hd6, s, r);
	cmp({s, r}, 10'h002);
	i_cpu.wr(8'hd0, 8'h55, r);
	cmp(r, 2'b10);
	wrn(A, 3, 40'h12_34_56);
	w(B, 8'h23);
	cmp(busy, 1'b0);
	w(B, 8'h01);
	cmp(busy, 1'b1);
	wait_idle();
	rdn(A, 4, v);
	cmp(v, 32'h1234_5678 / 16'h0123);
	rdn(B, 2, v);
	cmp(v, 32'h1234_5678 % 16'h0123);
endtask
task automatic t_div16;
	logic [39:0] v;
	wrn(A, 2, 40'hfedc);
	wrn(B, 2, 40'h0007);
	wait_idle();
	rdn(A, 4, v);
	cmp(v, 16'hfedc / 16'h0007);
	rdn(B, 2, v);
	cmp(v, 16'hfedc % 16'h0007);
endtask
task automatic t_corrupt;
	logic [7:0] d;
	logic [1:0] r;
	w(A, 8'h01);
	i_cpu.rd(B, d, r);
	repeat (40) @(posedge core_clk_i);
	cmp(busy, 1'b1);
	w(ST, 8'h00);
	repeat (2) @(posedge core_clk_i);
	cmp(busy, 1'b0);
endtask
task automatic t_mul_acc;
	logic [39:0] v;
	wait_idle();
	wrn(C, 5, 40'h12_3456_789a);
	rdn(C, 5, v);
	cmp(v, 40'h12_3456_789a);
	wrn(B, 2, 40'hbeef);
	wrn(A, 2, 40'h1234);
	wait_idle();
	rdn(A, 4, v);
	cmp(v, 32'hbeef * 32'h1234);
	rdn(C, 5, v);
	cmp(v, 40'h12_3456_789a + 40'hbeef * 40'h1234);
endtask
task automatic t_shift(input logic [7:0] ctl, input logic [31:0] exp);
	logic [39:0] v;
	wrn(A, 4, 40'h0001_2345);
	w(SN, ctl);
	wait_idle();
	rdn(A, 4, v);
	cmp(v, exp);
endtask
////////////////////////////////////////////////////////////////
always @(posedge hung) begin
	num_errors++;
	tally_and_finish();
end
initial begin
	logic [39:0] v;
	repeat (10) @(posedge core_clk_i);
	resetn_i <= 1'b1;
	@(posedge core_clk_i);
	t_div32();
	t_div16();
	t_corrupt();
	t_mul_acc();
	t_shift(8'h84, 32'h0001_2345 << 4);
	t_shift(8'h03, 32'h0001_2345 >> 3);
	t_shift(8'h40, 32'h0001_2345 << 15);
	rdn(SN, 1, v);
	cmp(v[4:0], 5'd15);
	tally_and_finish();
end
endmodule // math_accelerator_mac_tb
bind mac_top mac_checker i_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .busy_o(busy_o));
`default_nettype wire
